// >>> rtl/branch_increment_or_exec.sv
// Decode and execute for jump, plus-one, plus-one-skip and OR instructions.
// Assumes a word is offered while insn_valid_i is high and the next address
// is fetched from pc_o; the register file read takes one cycle.

// Operation
// - A jump loads its eleven-bit immediate into PC bits 10:0.
// - A jump copies latch bits 4:3 into PC bits 12:11; flags untouched.
// - A jump takes two instruction cycles and one program word.
// - Plus-one adds one to the addressed register and updates zero flag.
// - Target bit one writes the register, zero writes the accumulator.
// - Plus-one-skip stores the result, leaves flags, skips on zero.
// - On skip the fetched next word is discarded and a no-op runs.
// - OR combines accumulator and register, updates zero flag.
module branch_increment_or_exec #(
    parameter int INSN_W = exec_pkg::INSN_W,
    parameter int DATA_W = exec_pkg::DATA_W,
    parameter int PC_W = exec_pkg::PC_W,
    parameter int FADDR_W = exec_pkg::FADDR_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Fetched instruction
    input wire logic insn_valid_i,
    input wire logic [INSN_W-1:0] insn_i,
    input wire logic [DATA_W-1:0] upper_program_latch_i,
    // Core state
    output logic [PC_W-1:0] pc_o,
    output logic [DATA_W-1:0] acc_o,
    output logic zero_flag_o,
    output logic busy_o,
    output logic insn_done_o
);

    typedef enum logic [2:0] {
        ST_DECODE = 3'b001,
        ST_EXEC = 3'b010,
        ST_FLUSH = 3'b100
    } state_t;

    typedef enum logic [3:0] {
        OP_JUMP = 4'b0001,
        OP_PLUS_ONE = 4'b0010,
        OP_PLUS_SKIP = 4'b0100,
        OP_OR = 4'b1000
    } op_t;

    state_t state_q;
    op_t op_q;
    logic is_jump;
    logic is_inc;
    logic is_incsz;
    logic is_or;
    logic known;
    logic dest_q;
    logic [FADDR_W-1:0] faddr_q;
    logic [DATA_W-1:0] fdata;
    logic [DATA_W-1:0] result;
    logic we;
    logic [PC_W-1:0] pc_q;
    logic [DATA_W-1:0] acc_q;
    logic zero_q;
    logic take;
    logic exec_jump;
    logic exec_data;
    logic skip_hit;
    logic to_flush;
    logic [PC_W-1:0] jump_target;

    // ========================================================
    // Decode
    assign is_jump = insn_i[exec_pkg::JUMP_OP_MSB:exec_pkg::JUMP_OP_LSB]
        == exec_pkg::JUMP_OPCODE;
    assign is_inc = insn_i[exec_pkg::ALU_OP_MSB:exec_pkg::ALU_OP_LSB]
        == exec_pkg::PLUS_ONE_OPCODE;
    assign is_incsz = insn_i[exec_pkg::ALU_OP_MSB:exec_pkg::ALU_OP_LSB]
        == exec_pkg::PLUS_ONE_SKIP_OPCODE;
    assign is_or = insn_i[exec_pkg::ALU_OP_MSB:exec_pkg::ALU_OP_LSB]
        == exec_pkg::OR_ACC_REG_OPCODE;
    assign known = is_jump | is_inc | is_incsz | is_or;
    assign take = (state_q == ST_DECODE) && insn_valid_i && known;

    // ========================================================
    // Jump target
    // The immediate and latch bits are read in the execute cycle, so the
    // fetch stage must hold the word until the jump completes.
    // immediate low bits
    assign jump_target = {
        upper_program_latch_i[exec_pkg::LATCH_HI_MSB:exec_pkg::LATCH_HI_LSB],
        insn_i[exec_pkg::JUMP_K_MSB:0]
    };

    // ========================================================
    // Register file
    // The read is registered, so every data operation spends its first
    // cycle addressing and its second executing; jumps reuse that slot.
    file_reg_mem #(
        .AW(FADDR_W),
        .DW(DATA_W)
    ) u_file_reg_mem (
        .ref_clk_i(ref_clk_i),
        .we_i(we),
        .waddr_i(faddr_q),
        .wdata_i(result),
        .raddr_i(insn_i[FADDR_W-1:0]),
        .rdata_o(fdata)
    );

    // ========================================================
    // Arithmetic
    always_comb begin
        result = fdata;
        case (op_q)
            OP_PLUS_ONE: result = fdata + 8'h01;
            OP_PLUS_SKIP: result = fdata + 8'h01;
            OP_OR: result = acc_q | fdata;
            default: result = fdata;
        endcase
    end

    // ========================================================
    // Execute qualifiers
    assign exec_jump = (state_q == ST_EXEC) && (op_q == OP_JUMP);
    assign exec_data = (state_q == ST_EXEC) && (op_q != OP_JUMP);
    assign skip_hit = (op_q == OP_PLUS_SKIP) && (result == '0);
    assign to_flush = (op_q == OP_JUMP) || skip_hit;

    assign we = exec_data && dest_q;

    // ========================================================
    // Sequencer
    // A jump or a zero-result skip spends a flush cycle, so the word that
    // the fetch stage already holds is never executed.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= ST_DECODE;
        end else begin
            case (state_q)
                ST_DECODE: begin
                    if (take) begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (to_flush) begin
                        state_q <= ST_FLUSH;
                    end else begin
                        state_q <= ST_DECODE;
                    end
                end
                ST_FLUSH: begin
                    state_q <= ST_DECODE;
                end
                default: begin
                    state_q <= ST_DECODE;
                end
            endcase
        end
    end

    // ========================================================
    // Operand capture
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            op_q <= OP_PLUS_ONE;
            dest_q <= 1'b0;
            faddr_q <= '0;
        end else if (take) begin
            dest_q <= insn_i[exec_pkg::DEST_BIT];
            faddr_q <= insn_i[FADDR_W-1:0];
            if (is_jump) begin
                op_q <= OP_JUMP;
            end else if (is_inc) begin
                op_q <= OP_PLUS_ONE;
            end else if (is_incsz) begin
                op_q <= OP_PLUS_SKIP;
            end else begin
                op_q <= OP_OR;
            end
        end
    end

    // ========================================================
    // Program counter
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pc_q <= exec_pkg::PC_RESET;
        end else if (exec_jump) begin
            pc_q <= jump_target;
        end else if (exec_data ||
                (state_q == ST_FLUSH && op_q != OP_JUMP)) begin
            pc_q <= pc_q + 13'h0001;
        end
    end

    // ========================================================
    // Accumulator and zero flag
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            acc_q <= exec_pkg::ACC_RESET;
        end else if (exec_data && !dest_q) begin
            acc_q <= result;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            zero_q <= 1'b0;
        end else if (exec_data &&
                (op_q == OP_PLUS_ONE || op_q == OP_OR)) begin
            zero_q <= (result == '0);
        end
    end

    // A flush cycle keeps busy high so no new word is taken over the
    // discarded one.
    assign busy_o = (state_q != ST_DECODE);
    assign insn_done_o = (state_q == ST_EXEC && !to_flush)
        || state_q == ST_FLUSH;
    assign pc_o = pc_q;
    assign acc_o = acc_q;
    assign zero_flag_o = zero_q;

endmodule : branch_increment_or_exec

// >>> rtl/exec_pkg.sv
// Constants shared by the four-instruction decode and execute block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package exec_pkg;

    // ========================================================
    // Widths
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int FADDR_W = 7;

    // ========================================================
    // Opcode fields and values
    localparam int JUMP_OP_MSB = 13;
    localparam int JUMP_OP_LSB = 11;
    localparam logic [2:0] JUMP_OPCODE = 3'h5;
    localparam int ALU_OP_MSB = 13;
    localparam int ALU_OP_LSB = 8;
    localparam logic [5:0] PLUS_ONE_OPCODE = 6'h0A;
    localparam logic [5:0] PLUS_ONE_SKIP_OPCODE = 6'h0F;
    localparam logic [5:0] OR_ACC_REG_OPCODE = 6'h04;
    localparam int DEST_BIT = 7;
    localparam int JUMP_K_MSB = 10;
    localparam int LATCH_HI_MSB = 4;
    localparam int LATCH_HI_LSB = 3;

    // ========================================================
    // Reset values
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

endpackage : exec_pkg

// >>> rtl/file_reg_mem.sv
// Small file register memory with registered read data.
// Assumes one write and one read port in the core clock domain.
module file_reg_mem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // Clock
    input wire logic ref_clk_i,
    // Write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    // Read port
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);

    // Reset leaves the contents alone; they power up cleared so that a
    // read before the first write never returns an unknown value.
    logic [DW-1:0] mem_q [2**AW] = '{default: '0};

    // ========================================================
    // Storage
    always_ff @(posedge ref_clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        rdata_o <= mem_q[raddr_i];
    end

endmodule : file_reg_mem

// >>> verif/exec_sva.sv
// Port assertions for the decode and execute block.
// Assumes binding to the block's top module.
module exec_sva (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic insn_valid_i,
    input wire logic [13:0] insn_i,
    input wire logic [7:0] upper_program_latch_i,
    input wire logic [12:0] pc_o,
    input wire logic [7:0] acc_o,
    input wire logic zero_flag_o,
    input wire logic busy_o,
    input wire logic insn_done_o
);
    wire logic tk = insn_valid_i && !busy_o;
    wire logic dw = insn_i[7];
    wire logic a0 = acc_o == 8'h00;
    wire logic jmp = tk && insn_i[13:11] == 3'h5;
    wire logic inc = tk && insn_i[13:8] == 6'h0A;
    wire logic skp = tk && insn_i[13:8] == 6'h0F;
    wire logic ior = tk && insn_i[13:8] == 6'h04;
    wire logic [12:0] jt = {upper_program_latch_i[4:3], insn_i[10:0]};
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_jpc; jmp |=> ##1 pc_o == $past(jt, 2); endproperty
    a_jpc: assert property (p_jpc) else $error("jump pc");
    property p_jz; jmp |=> ##1 zero_flag_o == $past(zero_flag_o, 2);
    endproperty
    a_jz: assert property (p_jz) else $error("jump flag");
    property p_jlen; jmp |=> busy_o && !insn_done_o ##1 insn_done_o
        ##1 !busy_o; endproperty
    a_jlen: assert property (p_jlen) else $error("jump len");
    property p_incz; inc && !dw |=> ##1 zero_flag_o == a0; endproperty
    a_incz: assert property (p_incz) else $error("inc flag");
    property p_dst; (inc || ior) && dw |=> ##1 acc_o == $past(acc_o, 2);
    endproperty
    a_dst: assert property (p_dst) else $error("acc hit");
    property p_skz; skp |=> ##1 zero_flag_o == $past(zero_flag_o, 2);
    endproperty
    a_skz: assert property (p_skz) else $error("skip flag");
    // A skip shows as an extra busy cycle ending the instruction.
    property p_nop; skp && !dw |=> ##1 insn_done_o == a0 && busy_o == a0;
    endproperty
    a_nop: assert property (p_nop) else $error("skip nop");
    property p_ior; ior && !dw |=> ##1 zero_flag_o == a0
        && (acc_o | $past(acc_o, 2)) == acc_o; endproperty
    a_ior: assert property (p_ior) else $error("or");
    c_jmp: cover property (jmp);
    c_skip: cover property (skp ##2 insn_done_o);
    c_ior: cover property (ior && !dw);
endmodule : exec_sva
bind branch_increment_or_exec exec_sva u_sva (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .insn_valid_i(insn_valid_i),
    .insn_i(insn_i),
    .upper_program_latch_i(upper_program_latch_i),
    .pc_o(pc_o),
    .acc_o(acc_o),
    .zero_flag_o(zero_flag_o),
    .busy_o(busy_o),
    .insn_done_o(insn_done_o)
);

// >>> verif/tb.sv
// Self-checking bench for the decode and execute block.
// Assumes the file registers power up cleared, as the memory does.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, insn_valid_i = 1'b0, z_e = 1'b0;
    logic [13:0] insn_i = 14'h0000;
    logic [7:0] upper_program_latch_i = 8'h00, acc_e = 8'h00, acc_o, m = 8'h00;
    logic [12:0] pc_o, pc_e = 13'h0000;
    logic zero_flag_o, busy_o, insn_done_o;
    int fails = 0, n_compared = 0;
    branch_increment_or_exec dut (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .insn_valid_i(insn_valid_i),
        .insn_i(insn_i),
        .upper_program_latch_i(upper_program_latch_i),
        .pc_o(pc_o),
        .acc_o(acc_o),
        .zero_flag_o(zero_flag_o),
        .busy_o(busy_o),
        .insn_done_o(insn_done_o)
    );
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    task automatic cmp(logic [25:0] got, logic [25:0] exp);
        n_compared++;
        if (got !== exp) fails++;
        if (got !== exp) $display("unexpected %0t: %h not %h", $time, got, exp);
    endtask : cmp
    task automatic test_done();
        if (fails == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // Offers one word and checks state after its last cycle.
    task automatic run(logic [13:0] w, int c);
        int n;
        {insn_i, insn_valid_i} = {w, 1'b1};
        @(posedge ref_clk_i) #1 insn_valid_i = 1'b0;
        for (n = 1; insn_done_o !== 1'b1 && n < 5; n++)
            @(posedge ref_clk_i) #1;
        if (n == 5) fails++;
        if (n == 5) test_done();
        @(posedge ref_clk_i) #1;
        cmp({pc_o, acc_o, zero_flag_o, busy_o, 3'(n)},
            {pc_e, acc_e, z_e, 1'b0, 3'(c)});
    endtask : run
    task automatic op(logic [5:0] oc, logic d);
        logic [7:0] r;
        int c;
        r = oc == 6'h04 ? acc_e | m : m + 8'h01;
        c = oc == 6'h0F && r == 8'h00 ? 2 : 1;
        if (oc != 6'h0F) z_e = r == 8'h00;
        if (d) m = r;
        else acc_e = r;
        pc_e = pc_e + 13'(c);
        run({oc, d, 7'h05}, c);
    endtask : op
    task automatic t_jump(logic [7:0] lat, logic [10:0] k);
        upper_program_latch_i = lat;
        pc_e = {lat[4:3], k};
        run({3'h5, k}, 2);
    endtask : t_jump
    task automatic t_alu();
        op(6'h0A, 1'b1);
        op(6'h04, 1'b0);
        op(6'h0A, 1'b0);
        op(6'h04, 1'b1);
        op(6'h04, 1'b0);
    endtask : t_alu
    task automatic t_skip();
        for (int i = 0; i < 256 && m !== 8'hFE; i++)
            op(6'h0A, 1'b1);
        op(6'h0F, 1'b0);
        op(6'h0F, 1'b1);
        op(6'h0A, 1'b1);
        for (int i = 0; i < 256 && m !== 8'hFF; i++)
            op(6'h0F, 1'b1);
        op(6'h0F, 1'b0);
        op(6'h0F, 1'b1);
    endtask : t_skip
    initial begin
        repeat (3) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        t_alu();
        t_skip();
        t_jump(8'h18, 11'h7FF);
        t_jump(8'hE7, 11'h000);
        op(6'h04, 1'b0);
        test_done();
    end
endmodule : tb
